/* File: logic/prs_sequencer.sv */
// Purpose: Core supply rail mode sequencer issuing stored PMBus writes over I2C.
// Assumes: One regulator on the bus at a fixed address; no clock stretching.
// Notes:   Mode records are held in a constant table; see functional notes.
//
// Functional notes
// - Four rail modes: 0 off, 1 on, 2 lower voltage, 3 upper voltage.
// - Header holds command count in bits 15:8, mode id in 7:0; lower is 0x402.
// - Upper header encodes four commands, mode 3; that many are issued unless a byte is refused.
// - Lower and upper first command writes 0x00, 0x00 to select the page.
// - Second command writes 0x01, 0x00 to turn the output off.
// - Third command is three bytes: 0x21, low byte, high byte.
// - Output-setting command programs output to the 16-bit value of its data.
// - Lower mode target bytes are 0xB3 low, 0x00 high.
// - Upper mode target bytes are 0xBA low, 0x00 high.
// - Fourth command writes 0x01, 0x80 to turn the output back on.
// - On mode ends with a write of 0x01, 0x80.
// - Payload bytes continue into the next word from bit 7:0 upward.
`timescale 1ns/1ps
`include "prs_cfg.svh"
module prs_sequencer #(
	parameter logic [6:0] REG_ADDR = `PRS_REG_ADDR,
	parameter int         QTR      = `PRS_QTR_CYCLES
) (
	// Clock and reset.
	input  wire logic       sys_clk,
	input  wire logic       nrst,
	// Mode request.
	input  wire logic       mode_req,
	input  wire logic [1:0] mode_sel,
	output logic            busy,
	output logic            done,
	output logic            err,
	output logic [7:0]      cur_mode,
	// I2C pins; enable low pulls the line low.
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            scl_oe_n,
	output logic            sda_oe_n
);
	import prs_pkg::*;
	// The engine divider is sixteen bits wide, so longer quarter periods cannot be counted.
	if (QTR < 1 || QTR > 65536) begin : g_qtr_check
		$error("QTR outside the range the divider can count");
	end
	if (`PRS_REC_WORDS * `PRS_NUM_MODES != `PRS_REC_TOTAL) begin : g_rec_check
		$error("record table size does not match the mode count");
	end

	// ****************************************
	// Reset synchroniser
	// ****************************************
	logic [1:0] rst_sync_ff;
	logic       rst_n;
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rst_sync_ff <= 2'b00;
		end else begin
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
		end
	end
	// Every register reset by rst_n leaves reset on the same edge because the release passes two flops.
	assign rst_n = rst_sync_ff[1];

	// ****************************************
	// Pin synchronisers
	// ****************************************
	// SCL is read only to see a free bus, SDA also for the acknowledge; clock stretching is not honoured.
	logic [1:0] scl_sync_ff, sda_sync_ff;
	logic       bus_free;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_sync_ff <= 2'b11;
			sda_sync_ff <= 2'b11;
		end else begin
			scl_sync_ff <= {scl_sync_ff[0], scl_in};
			sda_sync_ff <= {sda_sync_ff[0], sda_in};
		end
	end
	assign bus_free = scl_sync_ff[1] & sda_sync_ff[1];

	// ****************************************
	// Mode record table
	// ****************************************
	logic [31:0] rec_mem [0:19];
	// Each record is a header word, then length-prefixed commands packed from bit 7:0 up.
	// The off record is padded to five words so every record starts on a fixed index.
	assign rec_mem[0]  = 32'h0000_0300;
	assign rec_mem[1]  = 32'h0200_0002;
	assign rec_mem[2]  = 32'h0102_1A02;
	assign rec_mem[3]  = 32'h0000_0000;
	assign rec_mem[4]  = 32'h0000_0000;

	// On record: the last command switches the output back on.
	assign rec_mem[5]  = 32'h0000_0301;
	assign rec_mem[6]  = 32'h0200_0002;
	assign rec_mem[7]  = 32'h0102_1A02;
	assign rec_mem[8]  = 32'h0000_0080;
	assign rec_mem[9]  = 32'h0000_0000;

	// Lower record.
	assign rec_mem[10] = 32'h0000_0402;
	assign rec_mem[11] = 32'h0200_0002;
	assign rec_mem[12] = 32'h2103_0001;
	assign rec_mem[13] = 32'h0102_00B3;
	assign rec_mem[14] = 32'h0000_0080;

	// Upper record.
	assign rec_mem[15] = 32'h0000_0403;
	assign rec_mem[16] = 32'h0200_0002;
	assign rec_mem[17] = 32'h2103_0001;
	assign rec_mem[18] = 32'h0102_00BA;
	assign rec_mem[19] = 32'h0000_0080;

	// ****************************************
	// Sequencer state
	// ****************************************
	prs_state_type st_ff, nxt_st;
	logic [4:0]  widx_ff, nxt_widx;
	logic [1:0]  bidx_ff, nxt_bidx;
	logic [7:0]  ncmd_ff, nxt_ncmd;
	logic [7:0]  nbyte_ff, nxt_nbyte;
	logic [7:0]  mode_ff, nxt_mode;
	logic [7:0]  tgt_ff, nxt_tgt;
	logic [7:0]  txb_ff, nxt_txb;
	logic        busy_ff, nxt_busy;
	logic        done_ff, nxt_done;
	logic        err_ff, nxt_err;
	logic        go_ff, nxt_go;
	prs_op_type  kind_ff, nxt_kind;
	logic        op_done, op_nack;
	logic [31:0] cur_word;
	logic [7:0]  cur_byte;
	assign cur_word = rec_mem[widx_ff];
	assign cur_byte = cur_word[{bidx_ff, 3'b000} +: 8];

	// ****************************************
	// Next-state logic
	// ****************************************
	always_comb begin
		nxt_st    = st_ff;
		nxt_widx  = widx_ff;
		nxt_bidx  = bidx_ff;
		nxt_ncmd  = ncmd_ff;
		nxt_nbyte = nbyte_ff;
		nxt_mode  = mode_ff;
		nxt_tgt   = tgt_ff;
		nxt_txb   = txb_ff;
		nxt_busy  = busy_ff;
		nxt_done  = 1'b0;
		nxt_err   = err_ff;
		nxt_go    = 1'b0;
		nxt_kind  = kind_ff;
		case (st_ff)
			PRS_IDLE: begin
				if (mode_req) begin
					nxt_tgt  = {6'h00, mode_sel};
					nxt_widx = 5'(mode_sel) * `PRS_REC_WORDS;
					nxt_bidx = 2'h0;
					nxt_busy = 1'b1;
					nxt_err  = 1'b0;
					nxt_st   = PRS_HDR;
				end
			end

			PRS_HDR: begin
				// A record with no commands finishes at once and still reports done.
				nxt_ncmd = cur_word[`PRS_HDR_CNT_HI:`PRS_HDR_CNT_LO];
				nxt_widx = widx_ff + 5'h01;
				nxt_bidx = 2'h0;
				nxt_st   = (cur_word[`PRS_HDR_CNT_HI:`PRS_HDR_CNT_LO] == 8'h00) ? PRS_DONE : PRS_LEN;
			end

			PRS_LEN: begin
				// A command starts only on a free bus; a line held low stalls the sequence here.
				if (bus_free) begin
					nxt_nbyte = cur_byte;
					{nxt_widx, nxt_bidx} = {widx_ff, bidx_ff} + 7'h01;
					nxt_kind = PRS_OP_START;
					nxt_go   = 1'b1;
					nxt_st   = PRS_START;
				end
			end

			PRS_START: begin
				if (op_done) begin
					nxt_txb  = {REG_ADDR, 1'b0};
					nxt_kind = PRS_OP_WRITE;
					nxt_go   = 1'b1;
					nxt_st   = PRS_XFER;
				end
			end

			PRS_BYTE: begin
				// Lanes run on across word boundaries; the byte count never restarts per word.
				nxt_txb   = cur_byte;
				{nxt_widx, nxt_bidx} = {widx_ff, bidx_ff} + 7'h01;
				nxt_nbyte = nbyte_ff - 8'h01;
				nxt_kind  = PRS_OP_WRITE;
				nxt_go    = 1'b1;
				nxt_st    = PRS_XFER;
			end

			PRS_XFER: begin
				// A refused byte ends the whole mode, but the stop is still sent to free the bus.
				if (op_done) begin
					nxt_go   = 1'b1;
					nxt_kind = PRS_OP_STOP;
					nxt_st   = PRS_STOP;
					if (op_nack) begin
						nxt_err = 1'b1;
					end else if (nbyte_ff != 8'h00) begin
						nxt_go = 1'b0;
						nxt_st = PRS_BYTE;
					end
				end
			end

			PRS_STOP: begin
				if (op_done) begin
					nxt_ncmd = ncmd_ff - 8'h01;
					if (err_ff || ncmd_ff == 8'h01) begin
						nxt_st = PRS_DONE;
					end else begin
						nxt_st = PRS_LEN;
					end
				end
			end

			PRS_DONE: begin
				// A failed mode keeps the old mode id, so the status shows what the rail still runs.
				nxt_busy = 1'b0;
				nxt_done = 1'b1;
				if (!err_ff) nxt_mode = tgt_ff;
				nxt_st = PRS_IDLE;
			end

			default: nxt_st = PRS_IDLE;
		endcase
	end

	// ****************************************
	// State registers
	// ****************************************
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_ff    <= PRS_IDLE;
			widx_ff  <= 5'h00;
			bidx_ff  <= 2'h0;
			ncmd_ff  <= 8'h00;
			nbyte_ff <= 8'h00;
			mode_ff  <= `PRS_MODE_OFF;
			tgt_ff   <= `PRS_MODE_OFF;
			txb_ff   <= 8'h00;
			busy_ff  <= 1'b0;
			done_ff  <= 1'b0;
			err_ff   <= 1'b0;
			go_ff    <= 1'b0;
			kind_ff  <= PRS_OP_START;
		end else begin
			st_ff    <= nxt_st;
			widx_ff  <= nxt_widx;
			bidx_ff  <= nxt_bidx;
			ncmd_ff  <= nxt_ncmd;
			nbyte_ff <= nxt_nbyte;
			mode_ff  <= nxt_mode;
			tgt_ff   <= nxt_tgt;
			txb_ff   <= nxt_txb;
			busy_ff  <= nxt_busy;
			done_ff  <= nxt_done;
			err_ff   <= nxt_err;
			go_ff    <= nxt_go;
			kind_ff  <= nxt_kind;
		end
	end

	// ****************************************
	// I2C engine
	// ****************************************
	prs_i2c_byte #(
		.QTR(QTR)
	) u_byte (
		.sys_clk  (sys_clk),
		.rst_n    (rst_n),
		.op_go    (go_ff),
		.op_kind  (kind_ff),
		.op_data  (txb_ff),
		.op_done  (op_done),
		.op_nack  (op_nack),
		.sda_in   (sda_sync_ff[1]),
		.scl_oe_n (scl_oe_n),
		.sda_oe_n (sda_oe_n)
	);

	// ****************************************
	// Outputs
	// ****************************************
	assign busy     = busy_ff;
	assign done     = done_ff;
	assign err      = err_ff;
	assign cur_mode = mode_ff;
endmodule

/* File: logic/prs_cfg.svh */
// Purpose: Constants for the core rail mode sequencer.
// Assumes: 40 MHz sys_clk, I2C at 100 kHz.
// Notes:   Definitions only.
`ifndef PRS_CFG_SVH
`define PRS_CFG_SVH
`define PRS_NUM_MODES      3'h4
`define PRS_MODE_OFF       8'h00
`define PRS_MODE_ON        8'h01
`define PRS_MODE_LOWER     8'h02
`define PRS_MODE_UPPER     8'h03
`define PRS_HDR_CNT_HI     15
`define PRS_HDR_CNT_LO     8
`define PRS_HDR_ID_HI      7
`define PRS_HDR_ID_LO      0
`define PRS_REC_WORDS      4'h5
`define PRS_REC_TOTAL      5'h14
`define PRS_REC_BASE_OFF   5'h00
`define PRS_REC_BASE_ON    5'h05
`define PRS_REC_BASE_LOWER 5'h0A
`define PRS_REC_BASE_UPPER 5'h0F
`define PRS_SCL_HZ         100000
`define PRS_CLK_HZ         40000000
`define PRS_QTR_CYCLES     (`PRS_CLK_HZ / (`PRS_SCL_HZ * 4))
`define PRS_REG_ADDR       7'h46
`endif

/* File: logic/prs_pkg.sv */
// Purpose: Types for the core rail mode sequencer.
// Assumes: Constants come from prs_cfg.svh.
// Notes:   States are one-hot.
package prs_pkg;
	typedef enum logic [7:0] {
		PRS_IDLE  = 8'h01,
		PRS_HDR   = 8'h02,
		PRS_LEN   = 8'h04,
		PRS_BYTE  = 8'h08,
		PRS_START = 8'h10,
		PRS_XFER  = 8'h20,
		PRS_STOP  = 8'h40,
		PRS_DONE  = 8'h80
	} prs_state_type;
	typedef enum logic [2:0] {
		PRS_OP_START = 3'h1,
		PRS_OP_WRITE = 3'h2,
		PRS_OP_STOP  = 3'h4
	} prs_op_type;
endpackage

/* File: logic/prs_i2c_byte.sv */
// Purpose: I2C bit engine: start, byte write with acknowledge check, stop.
// Assumes: Single controller on the bus, no clock stretching.
// Notes:   Open-drain pins; output enable low means pulling low.
`timescale 1ns/1ps
`include "prs_cfg.svh"
module prs_i2c_byte #(
	parameter int QTR = `PRS_QTR_CYCLES
) (
	// Clock and reset.
	input  wire logic              sys_clk,
	input  wire logic              rst_n,
	// Operation request.
	input  wire logic              op_go,
	input  wire prs_pkg::prs_op_type op_kind,
	input  wire logic [7:0]        op_data,
	output logic                   op_done,
	output logic                   op_nack,
	// Bus pins, already synchronised.
	input  wire logic              sda_in,
	output logic                   scl_oe_n,
	output logic                   sda_oe_n
);
	import prs_pkg::*;
	if (QTR < 1 || QTR > 65536) begin : g_qtr_check
		$error("QTR outside the range the divider can count");
	end
	logic [15:0] div_ff, nxt_div;
	logic [1:0]  ph_ff, nxt_ph;
	logic [3:0]  bit_ff, nxt_bit;
	logic [8:0]  sh_ff, nxt_sh;
	logic        busy_ff, nxt_busy;
	prs_op_type  kind_ff, nxt_kind;
	logic        scl_ff, nxt_scl;
	logic        sda_ff, nxt_sda;
	logic        done_ff, nxt_done;
	logic        nack_ff, nxt_nack;
	logic        tick;
	assign tick = (div_ff == 16'(QTR - 1));
	always_comb begin
		nxt_div  = busy_ff ? (tick ? 16'h0000 : div_ff + 16'h0001) : 16'h0000;
		nxt_ph   = ph_ff;
		nxt_bit  = bit_ff;
		nxt_sh   = sh_ff;
		nxt_busy = busy_ff;
		nxt_kind = kind_ff;
		nxt_scl  = scl_ff;
		nxt_sda  = sda_ff;
		nxt_done = 1'b0;
		nxt_nack = nack_ff;
		if (!busy_ff && op_go) begin
			nxt_busy = 1'b1;
			nxt_kind = op_kind;
			nxt_ph   = 2'h0;
			nxt_bit  = 4'h0;
			nxt_sh   = {op_data, 1'b1};
			nxt_nack = 1'b0;
		end else if (busy_ff && tick) begin
			nxt_ph = ph_ff + 2'h1;
			case (kind_ff)
				PRS_OP_START: begin
					case (ph_ff)
						2'h0: begin nxt_sda = 1'b1; nxt_scl = 1'b1; end
						2'h1: nxt_sda = 1'b0;
						2'h2: nxt_scl = 1'b0;
						default: begin nxt_busy = 1'b0; nxt_done = 1'b1; end
					endcase
				end
				PRS_OP_STOP: begin
					case (ph_ff)
						2'h0: nxt_sda = 1'b0;
						2'h1: nxt_scl = 1'b1;
						2'h2: nxt_sda = 1'b1;
						default: begin nxt_busy = 1'b0; nxt_done = 1'b1; end
					endcase
				end
				default: begin
					case (ph_ff)
						2'h0: nxt_sda = sh_ff[8];
						2'h1: nxt_scl = 1'b1;
						2'h2: begin
							// Ninth bit is released high so the regulator can drive it.
							if (bit_ff == 4'h8) nxt_nack = sda_in;
						end
						default: begin
							nxt_scl = 1'b0;
							nxt_sh  = {sh_ff[7:0], 1'b1};
							nxt_bit = bit_ff + 4'h1;
							if (bit_ff == 4'h8) begin
								nxt_busy = 1'b0;
								nxt_done = 1'b1;
							end
						end
					endcase
				end
			endcase
		end
	end
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_ff  <= 16'h0000;
			ph_ff   <= 2'h0;
			bit_ff  <= 4'h0;
			sh_ff   <= 9'h1FF;
			busy_ff <= 1'b0;
			kind_ff <= PRS_OP_START;
			scl_ff  <= 1'b1;
			sda_ff  <= 1'b1;
			done_ff <= 1'b0;
			nack_ff <= 1'b0;
		end else begin
			div_ff  <= nxt_div;
			ph_ff   <= nxt_ph;
			bit_ff  <= nxt_bit;
			sh_ff   <= nxt_sh;
			busy_ff <= nxt_busy;
			kind_ff <= nxt_kind;
			scl_ff  <= nxt_scl;
			sda_ff  <= nxt_sda;
			done_ff <= nxt_done;
			nack_ff <= nxt_nack;
		end
	end
	assign op_done  = done_ff;
	assign op_nack  = nack_ff;
	assign scl_oe_n = scl_ff;
	assign sda_oe_n = sda_ff;
endmodule

/* File: verification/prs_sequencer_asserts.sv */
// Purpose: Port-level checks for the core rail mode sequencer.
// Assumes: Sees only the top module ports.
// Notes:   Bound to every prs_sequencer instance.
`timescale 1ns/1ps
module prs_seq_chk #(
	parameter int QTR = 100
) (
	// Clock and reset.
	input wire logic       sys_clk,
	input wire logic       nrst,
	// Request and status.
	input wire logic       mode_req,
	input wire logic [1:0] mode_sel,
	input wire logic       busy,
	input wire logic       done,
	input wire logic       err,
	input wire logic [7:0] cur_mode,
	// Bus pins.
	input wire logic       scl_in,
	input wire logic       sda_in,
	input wire logic       scl_oe_n,
	input wire logic       sda_oe_n
);
	// ****************
	// Assertions
	// ****************
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	chk_req_taken: assert property (!busy && !done && mode_req |=> busy)
		else $error("request not taken");
	chk_done_pulse: assert property (done |=> !done)
		else $error("done longer than one cycle");
	chk_busy_holds: assert property (busy && !done |=> busy || done)
		else $error("busy dropped without done");
	chk_done_idle: assert property (done && !mode_req |=> !busy)
		else $error("busy after done");
	chk_mode_range: assert property (cur_mode <= 8'h03)
		else $error("mode id out of range");
	chk_mode_update: assert property ($changed(cur_mode) |-> done)
		else $error("mode changed without done");
	chk_nack_keeps: assert property (done && err |-> $stable(cur_mode))
		else $error("mode updated on error");
	chk_err_holds: assert property (!busy && !mode_req |=> $stable(err))
		else $error("error flag moved in idle");
	chk_idle_lines: assert property (!busy && !done |-> scl_oe_n && sda_oe_n)
		else $error("bus not released in idle");
endmodule
bind prs_sequencer prs_seq_chk #(.QTR(QTR)) i_prs_seq_chk (.sys_clk, .nrst, .mode_req, .mode_sel, .busy, .done,
	.err, .cur_mode, .scl_in, .sda_in, .scl_oe_n, .sda_oe_n);

/* File: verification/prs_reg_model.sv */
// Purpose: Behavioural regulator on the I2C bus for the sequencer bench.
// Assumes: Both lines have pull-ups; no clock stretching.
// Notes:   Logs every byte received, address bytes included.
`timescale 1ns/1ps
module prs_reg_model (
	// Bus wires.
	input  wire logic scl,
	input  wire logic sda,
	// Fault control.
	input  wire logic nack_en,
	output logic      sda_oe_n
);
	// ****************
	// Byte capture
	// ****************
	logic [7:0] sh;
	int         bc;
	logic [7:0] log_q[$];
	initial begin
		sda_oe_n = 1'b1;
		bc = 0;
	end
	// A start condition restarts the bit count.
	always @(negedge sda) if (scl) bc = 0;
	always @(posedge scl) begin
		if (bc < 8) sh = {sh[6:0], sda};
		bc++;
		if (bc == 8) log_q.push_back(sh);
	end
	// Withholding the acknowledge is the only fault, so the abort path can be reached.
	always @(negedge scl) begin
		sda_oe_n = (bc == 8) ? nack_en : 1'b1;
		if (bc >= 9) bc = 0;
	end
endmodule

/* File: verification/tb.sv */
// Purpose: Self-checking bench for the core rail mode sequencer.
// Assumes: Short quarter period in simulation.
// Notes:   Byte streams are checked at the regulator model.
`timescale 1ns/1ps
module tb;
	// ****************
	// Bench setup
	// ****************
	logic            sys_clk  = 1'b0;
	logic            nrst     = 1'b0;
	logic            mode_req = 1'b0;
	logic [1:0]      mode_sel = 2'h0;
	logic            nack_en  = 1'b0;
	logic            busy;
	logic            done;
	logic            err;
	logic [7:0]      cur_mode;
	logic            scl_oe_n;
	logic            sda_oe_n;
	logic            m_oe_n;
	wire logic       sda      = sda_oe_n & m_oe_n;
	int              error_cnt    = 0;
	int              total_checks = 0;
	localparam logic [7:0] AW = 8'h8C;
	always #12.5 sys_clk = ~sys_clk;
	prs_sequencer #(.QTR(2)) i_prs_sequencer (.sys_clk, .nrst, .mode_req, .mode_sel, .busy, .done, .err,
		.cur_mode, .scl_in(scl_oe_n), .sda_in(sda), .scl_oe_n, .sda_oe_n);
	prs_reg_model i_prs_reg_model (.scl(scl_oe_n), .sda, .nack_en, .sda_oe_n(m_oe_n));
	// ****************
	// Tasks
	// ****************
	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic close_out();
		$display("checks=%0d errors=%0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic run_mode(input logic [1:0] sel);
		int n;
		i_prs_reg_model.log_q.delete();
		@(negedge sys_clk);
		mode_req = 1'b1;
		mode_sel = sel;
		@(negedge sys_clk);
		mode_req = 1'b0;
		cmp8({7'h00, busy}, 8'h01);
		for (n = 0; n < 5000 && done !== 1'b1; n++) @(negedge sys_clk);
		if (n == 5000) begin
			error_cnt++;
			close_out();
		end
		cmp8({7'h00, busy}, 8'h00);
	endtask
	task automatic chk_log(input logic [7:0] exp[$]);
		cmp8(8'(i_prs_reg_model.log_q.size()), 8'(exp.size()));
		foreach (exp[i]) if (i < i_prs_reg_model.log_q.size()) cmp8(i_prs_reg_model.log_q[i], exp[i]);
	endtask
	task automatic sc_rail(input logic [1:0] sel, input logic [7:0] lo);
		run_mode(sel);
		chk_log('{AW, 8'h00, 8'h00, AW, 8'h01, 8'h00, AW, 8'h21, lo, 8'h00, AW, 8'h01, 8'h80});
		cmp8({7'h00, err}, 8'h00);
		cmp8(cur_mode, {6'h00, sel});
	endtask
	task automatic sc_on();
		run_mode(2'h1);
		chk_log('{AW, 8'h00, 8'h00, AW, 8'h02, 8'h1A, AW, 8'h01, 8'h80});
		cmp8(cur_mode, 8'h01);
	endtask
	task automatic sc_nack();
		nack_en = 1'b1;
		run_mode(2'h2);
		nack_en = 1'b0;
		chk_log('{AW});
		cmp8({7'h00, err}, 8'h01);
		cmp8(cur_mode, 8'h01);
	endtask
	task automatic sc_off();
		run_mode(2'h0);
		chk_log('{AW, 8'h00, 8'h00, AW, 8'h02, 8'h1A, AW, 8'h01, 8'h00});
		cmp8({7'h00, err}, 8'h00);
		cmp8(cur_mode, 8'h00);
	endtask
	// ****************
	// Main sequence
	// ****************
	initial begin
		repeat (6) @(negedge sys_clk);
		nrst = 1'b1;
		repeat (4) @(negedge sys_clk);
		cmp8({6'h00, scl_oe_n, sda_oe_n}, 8'h03);
		sc_rail(2'h2, 8'hB3);
		sc_rail(2'h3, 8'hBA);
		sc_on();
		sc_nack();
		sc_rail(2'h3, 8'hBA);
		sc_off();
		close_out();
	end
endmodule
